// [rtl/frt_regs.sv]
/*
 * Tape assignment, rate/precompensation select and main status
 * registers, data rate decoding onto the drive density outputs,
 * manual low power and software reset control.
 * Assumes the controller core supplies status, drive select and the
 * per-drive configuration pairs on the same clock.
 */
// The address-and-strobe port was decided locally.
// What this block does
// - Tape select bits 1:0 name tape drive: none, drive 1, 2 or 3.
// - Drive 0 is boot drive and never becomes the tape drive.
// - Software reset leaves tape assignment unchanged; only hardware reset alters it.
// - Normal mode tape register reads return zero in bits 7:2.
// - Enhanced mode two reads: tape select, boot drive, drive type, reserved.
// - Drive type id is the configuration pair picked by drive select.
// - Rate register: reset bit7, low power bit6, zero, code 4:2, rate 1:0.
// - Data rate comes from whichever of rate or config register was written last.
// - Hardware reset loads 02H; software reset clears only the low power bit of the rate register.
// - Code 111 zero delay, 001-110 steps, 000 rate default.
// - Default delay 20.8 ns at 2M, 41.67 ns at 1M, else 125 ns.
// - Precompensation starts at track 0 unless configure changes it.
// - Low power bit stops controller until software reset or data/status access.
// - Bit 7 resets controller like output register reset, then clears itself.
// - MFM rate decoded from drive rate pair and rate select; FM is half.
// - Density select high for 1M and 500K; rate bits follow rate select.
// - Drive density outputs follow drive type pair mapping.
// - Main status reads at any time, without wait; a read ends low power.
// - Status: transfer, direction, non-DMA, command busy, reserved, seek busy.
// - Seek busy flags are one during seeks, implied seeks and recalibrates.
// - Transfer bit one allows data access; direction one means host read.
// - Output register reset bit zero holds reset until one; rates unaffected.
// - Command busy rises on accepted command byte, falls after result phase.
`include "frt_defs.svh"

module frt_regs
    import frt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire frt_bus_type bus,
    output logic [7:0] rd_data,
    input wire frt_status_type status,
    input wire logic enhanced_mode_two,
    input wire logic [1:0] drive_select,
    input wire logic [1:0] boot_drive,
    input wire logic [7:0] drive_type_cfg,
    input wire logic [7:0] drive_rate_cfg,
    input wire logic [7:0] cur_track,
    input wire logic [7:0] code_a_start_track,
    output logic ctrl_reset,
    output logic low_power,
    output logic tape_drive_active,
    output logic [1:0] rate_bits,
    output logic density_select,
    output logic [1:0] drive_density_out,
    output logic [11:0] mfm_rate_kbps,
    output logic [11:0] fm_rate_kbps,
    output logic [17:0] code_a_delay_ps,
    output logic code_a_enable
);

    localparam logic [4:0] SWRST_CYC = 5'(`FRT_SWRST_CYC);

    frt_state_type s_q;
    frt_state_type s_d;
    logic wr_tape;
    logic wr_rate;
    logic wr_cfg;
    logic wr_digout;
    logic rd_tape;
    logic rd_stat;
    logic data_acc;
    logic [1:0] type_pair;
    logic [1:0] rate_pair;
    logic [11:0] kbps;
    logic [17:0] step_ps;
    logic [17:0] dflt_ps;

    // Pick one two-bit pair of a per-drive configuration byte
    function automatic logic [1:0] pick_pair(input logic [7:0] cfg, input logic [1:0] idx);
        logic [1:0] r;
        r = 2'h0;
        case (idx)
            2'h0: r = cfg[1:0];
            2'h1: r = cfg[3:2];
            2'h2: r = cfg[5:4];
            default: r = cfg[7:6];
        endcase
        return r;
    endfunction

    assign wr_tape = bus.wr && bus.addr == `FRT_OFS_TAPE;
    assign wr_rate = bus.wr && bus.addr == `FRT_OFS_RATE;
    assign wr_cfg = bus.wr && bus.addr == `FRT_OFS_CFGCTL;
    assign wr_digout = bus.wr && bus.addr == `FRT_OFS_DIGOUT;
    assign rd_tape = bus.rd && bus.addr == `FRT_OFS_TAPE;
    assign rd_stat = bus.rd && bus.addr == `FRT_OFS_STATUS;
    assign data_acc = (bus.rd || bus.wr) && bus.addr == `FRT_OFS_DATA;

    // Per-drive pairs from outside configuration
    assign type_pair = pick_pair(drive_type_cfg, drive_select);
    assign rate_pair = pick_pair(drive_rate_cfg, drive_select);

    always_comb begin
        kbps = `FRT_KBPS_250K;
        case (s_q.rate_sel)
            `FRT_SEL_1M: kbps = `FRT_KBPS_1M;
            `FRT_SEL_500K: kbps = `FRT_KBPS_500K;
            `FRT_SEL_250K: kbps = `FRT_KBPS_250K;
            default: begin
                case (rate_pair)
                    2'h1: kbps = `FRT_KBPS_500K;
                    2'h2: kbps = `FRT_KBPS_2M;
                    default: kbps = `FRT_KBPS_300K;
                endcase
            end
        endcase
    end

    always_comb begin
        step_ps = (kbps == `FRT_KBPS_2M) ? `FRT_STEP_FAST_PS : `FRT_STEP_SLOW_PS;
        dflt_ps = `FRT_DEF_SLOW_PS;
        if (kbps == `FRT_KBPS_2M) begin
            dflt_ps = `FRT_STEP_FAST_PS;
        end else if (kbps == `FRT_KBPS_1M) begin
            dflt_ps = `FRT_STEP_SLOW_PS;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rd_data = 8'h00;
        // Software reset pulse counts down
        if (s_q.swrst_cnt != 5'h0) begin
            s_d.swrst_cnt = s_q.swrst_cnt - 5'h1;
        end
        if (wr_digout) begin
            s_d.reset_hold = ~bus.wdata[`FRT_DO_NRESET];
        end
        if (wr_tape) begin
            s_d.tape_sel = bus.wdata[1:0];
        end
        if (wr_rate) begin
            s_d.rate_sel = bus.wdata[`FRT_RS_RATE_HI:`FRT_RS_RATE_LO];
            s_d.code_a = bus.wdata[`FRT_RS_CODE_HI:`FRT_RS_CODE_LO];
            s_d.low_power = bus.wdata[`FRT_RS_LOWPWR];
            if (bus.wdata[`FRT_RS_SWRST]) begin
                s_d.swrst_cnt = SWRST_CYC;
            end
        end
        if (wr_cfg) begin
            s_d.rate_sel = bus.wdata[1:0];
        end
        // Leave low power on reset or data/status access
        if (ctrl_reset || rd_stat || data_acc || (wr_rate && bus.wdata[`FRT_RS_SWRST])) begin
            s_d.low_power = 1'b0;
        end
        if (rd_tape) begin
            if (enhanced_mode_two) begin
                s_d.rd_data = {2'h0, type_pair, boot_drive, s_q.tape_sel};
            end else begin
                s_d.rd_data = {6'h00, s_q.tape_sel};
            end
        end
        if (rd_stat) begin
            // Plain copy of live status, no side effect on it
            s_d.rd_data = {status.host_may_transfer, status.transfer_direction,
                status.non_dma, status.cmd_busy, 2'h0,
                status.seek_busy_b, status.seek_busy_a};
        end
        s_d.rate_kbps = kbps;
        s_d.density_select = (s_q.rate_sel == `FRT_SEL_1M) ||
            (s_q.rate_sel == `FRT_SEL_500K);
        case (type_pair)
            2'h0: s_d.drive_density_out = {s_q.rate_sel[0], s_d.density_select};
            2'h2: s_d.drive_density_out = {s_q.rate_sel[0], s_q.rate_sel[1]};
            2'h1: s_d.drive_density_out = {s_q.rate_sel[0], ~s_d.density_select};
            default: s_d.drive_density_out = {s_q.rate_sel[1], s_q.rate_sel[0]};
        endcase
        case (s_q.code_a)
            `FRT_CODE_ZERO: s_d.code_a_ps = 18'h0_0000;
            `FRT_CODE_DEFAULT: s_d.code_a_ps = dflt_ps;
            default: s_d.code_a_ps = 18'(step_ps * s_q.code_a);
        endcase
        s_d.code_a_en = cur_track >= code_a_start_track;
        s_d.tape_active = (s_q.tape_sel != 2'h0) && (drive_select == s_q.tape_sel);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.tape_sel <= `FRT_TAPE_RST;
            s_q.rate_sel <= `FRT_RATE_SEL_RST;
            s_q.code_a <= `FRT_CODE_RST;
            s_q.reset_hold <= 1'b1;
            s_q.density_select <= 1'b1;
            s_q.rate_kbps <= `FRT_KBPS_250K;
            s_q.code_a_ps <= `FRT_DEF_SLOW_PS;
            s_q.code_a_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign ctrl_reset = s_q.reset_hold || (s_q.swrst_cnt != 5'h0);
    assign low_power = s_q.low_power;
    assign tape_drive_active = s_q.tape_active;
    assign rate_bits = s_q.rate_sel;
    assign density_select = s_q.density_select;
    assign drive_density_out = s_q.drive_density_out;
    assign mfm_rate_kbps = s_q.rate_kbps;
    assign fm_rate_kbps = {1'b0, s_q.rate_kbps[11:1]};
    assign code_a_delay_ps = s_q.code_a_ps;
    assign code_a_enable = s_q.code_a_en;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    tape_normal_read_a: assert property (
        rd_tape && !enhanced_mode_two |=> rd_data[7:2] == 6'h00)
        else $error("tape register upper bits not zero");
    tape_never_boot_a: assert property (
        drive_select == 2'h0 |=> !tape_drive_active)
        else $error("drive 0 marked as tape");
    tape_keeps_reset_a: assert property (
        ctrl_reset && !wr_tape |=> $stable(s_q.tape_sel))
        else $error("tape assignment changed by software reset");
    swrst_pulse_len_a: assert property (
        wr_rate && bus.wdata[7] |=> ctrl_reset [*8] ##18 (ctrl_reset == s_q.reset_hold))
        else $error("software reset pulse length wrong");
    cfg_rate_wins_a: assert property (
        wr_cfg |=> rate_bits == $past(bus.wdata[1:0]))
        else $error("config write did not set rate");
    lowpwr_exit_a: assert property (
        low_power && rd_stat |=> !low_power)
        else $error("status read did not leave low power");
    status_read_a: assert property (
        rd_stat |=> rd_data == {$past(status.host_may_transfer),
            $past(status.transfer_direction), $past(status.non_dma),
            $past(status.cmd_busy), 2'h0, $past(status.seek_busy_b),
            $past(status.seek_busy_a)})
        else $error("status read data wrong");
    rate_1m_decode_a: assert property (
        s_q.rate_sel == `FRT_SEL_1M |=> mfm_rate_kbps == `FRT_KBPS_1M && density_select)
        else $error("1M rate decode wrong");
    code_a_zero_a: assert property (
        s_q.code_a == `FRT_CODE_ZERO |=> code_a_delay_ps == 18'h0_0000)
        else $error("code 111 delay not zero");
    hw_rst_rate_a: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> rate_bits == `FRT_RATE_SEL_RST && s_q.code_a == `FRT_CODE_RST)
        else $error("hardware reset rate value wrong");
    swrst_lowpwr_a: assert property (
        wr_rate && bus.wdata[`FRT_RS_SWRST] |=> !low_power)
        else $error("software reset did not leave low power");
    reset_hold_a: assert property (
        wr_digout && !bus.wdata[`FRT_DO_NRESET] |=> ctrl_reset)
        else $error("reset hold not entered");
    tape_type_id_a: assert property (
        rd_tape && enhanced_mode_two |=> rd_data[5:4] == $past(type_pair))
        else $error("drive type id wrong");

    swrst_seen_c: cover property (wr_rate && bus.wdata[7]);
    enh_read_c: cover property (rd_tape && enhanced_mode_two);
    lowpwr_seen_c: cover property (low_power ##1 rd_stat);
    cfg_write_c: cover property (wr_cfg);

endmodule

// [rtl/frt_defs.svh]
/*
 * Offsets, reset values, field positions and timing counts of the
 * rate, tape and main status register block.
 * Assumes a 250 MHz controller clock and byte-wide host accesses.
 */
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

// Host offsets
`define FRT_ADDR_W 10
`define FRT_OFS_DIGOUT 10'h3f2
`define FRT_OFS_TAPE 10'h3f3
`define FRT_OFS_RATE 10'h3f4
`define FRT_OFS_STATUS 10'h3f4
`define FRT_OFS_DATA 10'h3f5
`define FRT_OFS_CFGCTL 10'h3f7

// Reset values
`define FRT_TAPE_RST 2'h0
`define FRT_RATE_SEL_RST 2'h2
`define FRT_CODE_RST 3'h0

// Rate select and output register fields
`define FRT_RS_SWRST 7
`define FRT_RS_LOWPWR 6
`define FRT_RS_CODE_HI 4
`define FRT_RS_CODE_LO 2
`define FRT_RS_RATE_HI 1
`define FRT_RS_RATE_LO 0
`define FRT_DO_NRESET 2

// Rate select encodings
`define FRT_SEL_500K 2'h0
`define FRT_SEL_ALT 2'h1
`define FRT_SEL_250K 2'h2
`define FRT_SEL_1M 2'h3

// MFM data rates in Kbps
`define FRT_KBPS_2M 12'h7d0
`define FRT_KBPS_1M 12'h3e8
`define FRT_KBPS_500K 12'h1f4
`define FRT_KBPS_300K 12'h12c
`define FRT_KBPS_250K 12'h0fa

// Precompensation codes and delays in ps
`define FRT_CODE_DEFAULT 3'h0
`define FRT_CODE_ZERO 3'h7
`define FRT_STEP_SLOW_PS 18'h0_a2c6
`define FRT_STEP_FAST_PS 18'h0_5140
`define FRT_DEF_SLOW_PS 18'h1_e848

// Software reset pulse: least duration and clock period in ns
`define FRT_SWRST_NS 100
`define FRT_CLK_NS 4
`define FRT_SWRST_CYC ((`FRT_SWRST_NS + `FRT_CLK_NS - 1) / `FRT_CLK_NS)

`endif

// [rtl/frt_pkg.sv]
/*
 * Types of the rate, tape and main status register block.
 * Assumes frt_defs.svh is available on the include path.
 */
`include "frt_defs.svh"

package frt_pkg;

    typedef struct packed {
        logic [`FRT_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } frt_bus_type;

    typedef struct packed {
        logic host_may_transfer;
        logic transfer_direction;
        logic non_dma;
        logic cmd_busy;
        logic seek_busy_b;
        logic seek_busy_a;
    } frt_status_type;

    typedef struct packed {
        logic [1:0] tape_sel;
        logic [1:0] rate_sel;
        logic [2:0] code_a;
        logic low_power;
        logic reset_hold;
        logic [4:0] swrst_cnt;
        logic [7:0] rd_data;
        logic [1:0] drive_density_out;
        logic density_select;
        logic [11:0] rate_kbps;
        logic [17:0] code_a_ps;
        logic code_a_en;
        logic tape_active;
    } frt_state_type;

endpackage

// [test/frt_host.sv]
/*
 * Host model issuing byte accesses on the register bus.
 * Assumes one clock shared with the block and a slave that never stalls.
 */
`include "frt_defs.svh"
module frt_host
    import frt_pkg::*;
(
    input wire logic clk,
    output frt_bus_type bus,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus = '0;

    task automatic wr(input logic [`FRT_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [`FRT_ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // Data byte once status allows a host write, or anyway after 16 status reads
    task automatic data_wr(input logic [7:0] d);
        logic [7:0] s;
        for (int i = 0; i < 16; i++) begin
            rd(`FRT_OFS_STATUS, s);
            if (s[7] && !s[6]) break;
        end
        wr(`FRT_OFS_DATA, d);
    endtask
endmodule

// [test/frt_regs_bench.sv]
/*
 * Self-checking bench of the rate, tape and status register block.
 * Assumes frt_host drives the bus and the core inputs come from here.
 */
`include "frt_defs.svh"
module frt_regs_bench
    import frt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    frt_bus_type bus;
    frt_status_type status = '0;
    logic enhanced_mode_two = 1'b0;
    logic [1:0] drive_select = 2'h0, boot_drive = 2'h1;
    logic [7:0] drive_type_cfg = 8'he4, drive_rate_cfg = 8'h00;
    logic [7:0] cur_track = 8'h00, code_a_start_track = 8'h00, rd_data, rv;
    logic ctrl_reset, low_power, tape_drive_active, density_select, code_a_enable;
    logic [1:0] rate_bits, drive_density_out;
    logic [11:0] mfm_rate_kbps, fm_rate_kbps;
    logic [17:0] code_a_delay_ps;
    int n_mismatch = 0;
    int n_compared = 0;

    frt_host frt_host_inst (.clk, .bus, .rd_data);
    frt_regs frt_regs_inst (.clk, .sys_rst, .bus, .rd_data, .status, .enhanced_mode_two,
        .drive_select, .boot_drive, .drive_type_cfg, .drive_rate_cfg, .cur_track,
        .code_a_start_track, .ctrl_reset, .low_power, .tape_drive_active, .rate_bits,
        .density_select, .drive_density_out, .mfm_rate_kbps, .fm_rate_kbps,
        .code_a_delay_ps, .code_a_enable);

    always #2 clk = ~clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic int kbps(input int r, input int s);
        case (s)
            0: return 500;
            1: return r == 2 ? 2000 : (r == 1 ? 500 : 300);
            2: return 250;
            default: return 1000;
        endcase
    endfunction

    function automatic logic [1:0] ddo(input int t, input int s);
        logic d;
        d = (s == 0 || s == 3);
        case (t)
            0: return {s[0], d};
            1: return {s[0], ~d};
            2: return {s[0], s[1]};
            default: return {s[1], s[0]};
        endcase
    endfunction

    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        int k;
        int p;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        settle;
        chk(rate_bits, 2);
        chk(mfm_rate_kbps, 250);
        chk(code_a_delay_ps, 125000);
        chk(code_a_enable, 1);
        chk(ctrl_reset, 1);
        frt_host_inst.rd(`FRT_OFS_TAPE, rv);
        chk(rv, 0);
        // Every tape code against every drive select
        for (int tv = 0; tv < 4; tv++) begin
            frt_host_inst.wr(`FRT_OFS_TAPE, 8'hfc | 8'(tv));
            @(posedge clk);
            enhanced_mode_two <= 1'b0;
            frt_host_inst.rd(`FRT_OFS_TAPE, rv);
            chk(rv, tv);
            for (int ds = 0; ds < 4; ds++) begin
                @(posedge clk);
                drive_select <= 2'(ds);
                enhanced_mode_two <= 1'b1;
                settle;
                chk(tape_drive_active, tv != 0 && tv == ds);
                frt_host_inst.rd(`FRT_OFS_TAPE, rv);
                chk(rv, {2'b00, 2'(ds), 2'b01, 2'(tv)});
            end
        end
        @(posedge clk);
        enhanced_mode_two <= 1'b0;
        // Rate decode; drive rate pairs kept to the recommended set
        for (int t = 0; t < 4; t++)
            for (int r = 0; r < 3; r++)
                for (int s = 0; s < 4; s++) begin
                    @(posedge clk);
                    drive_type_cfg <= {4{2'(t)}};
                    drive_rate_cfg <= {4{2'(r)}};
                    frt_host_inst.wr(`FRT_OFS_RATE, 8'(s));
                    settle;
                    k = kbps(r, s);
                    chk(mfm_rate_kbps, k);
                    chk(fm_rate_kbps, k / 2);
                    chk(density_select, s == 0 || s == 3);
                    chk(rate_bits, s);
                    chk(drive_density_out, ddo(t, s));
                    p = k == 2000 ? 20800 : (k == 1000 ? 41670 : 125000);
                    chk(code_a_delay_ps, p);
                end
        for (int f = 0; f < 2; f++)
            for (int c = 1; c < 8; c++) begin
                frt_host_inst.wr(`FRT_OFS_RATE, {3'b000, 3'(c), f ? 2'b01 : 2'b10});
                settle;
                chk(code_a_delay_ps, c == 7 ? 0 : c * (f ? 20800 : 41670));
            end
        frt_host_inst.wr(`FRT_OFS_CFGCTL, 8'h03);
        settle;
        chk(mfm_rate_kbps, 1000);
        frt_host_inst.wr(`FRT_OFS_RATE, 8'h02);
        settle;
        chk(mfm_rate_kbps, 250);
        frt_host_inst.wr(`FRT_OFS_CFGCTL, 8'h00);
        settle;
        chk(mfm_rate_kbps, 500);
        frt_host_inst.wr(`FRT_OFS_DIGOUT, 8'h04);
        settle;
        chk(ctrl_reset, 0);
        frt_host_inst.wr(`FRT_OFS_RATE, 8'h40);
        settle;
        chk(low_power, 1);
        frt_host_inst.wr(`FRT_OFS_RATE, 8'hc3);
        #1;
        chk(ctrl_reset, 1);
        chk(low_power, 0);
        repeat (24) @(posedge clk);
        #1;
        chk(ctrl_reset, 1);
        @(posedge clk);
        #1;
        chk(ctrl_reset, 0);
        chk(rate_bits, 3);
        frt_host_inst.rd(`FRT_OFS_TAPE, rv);
        chk(rv, 3);
        frt_host_inst.wr(`FRT_OFS_DIGOUT, 8'h00);
        settle;
        chk(ctrl_reset, 1);
        chk(rate_bits, 3);
        frt_host_inst.wr(`FRT_OFS_DIGOUT, 8'h04);
        frt_host_inst.wr(`FRT_OFS_RATE, 8'h42);
        @(posedge clk);
        status <= 6'b101110;
        chk(low_power, 1);
        frt_host_inst.rd(`FRT_OFS_STATUS, rv);
        chk(rv, 8'hb2);
        chk(low_power, 0);
        frt_host_inst.rd(`FRT_OFS_STATUS, rv);
        chk(rv, 8'hb2);
        @(posedge clk);
        status <= 6'b110001;
        frt_host_inst.rd(`FRT_OFS_STATUS, rv);
        chk(rv, 8'hc1);
        @(posedge clk);
        status <= 6'b100000;
        frt_host_inst.wr(`FRT_OFS_RATE, 8'h42);
        frt_host_inst.data_wr(8'h5a);
        settle;
        chk(low_power, 0);
        frt_host_inst.rd(10'h3f0, rv);
        chk(rv, 0);
        @(posedge clk);
        code_a_start_track <= 8'h05;
        settle;
        chk(code_a_enable, 0);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        settle;
        frt_host_inst.rd(`FRT_OFS_TAPE, rv);
        chk(rv, 0);
        chk(rate_bits, 2);
        wrap_up;
    end
endmodule
